// *** rtl/prm_top.sv ***
`timescale 1ns/10ps
// Operation
// RQ1 - Catch pod presence at startup and drive the active-low present output.
// RQ2 - First mode: level selects only matter at a strobe rising edge.
// RQ3 - A falling strobe leaves the rail on or off as it was.
// RQ4 - Fabric turns the rail off with selects 00 and a strobe rise.
// RQ5 - Second mode, strobe low at startup: use highest common module level.
// RQ6 - No common module level flags a fault shown on the status LED.
// RQ7 - Strobe high at startup sets the rail from the selects regardless.
// RQ8 - Select code 00 off, 01 1.2V, 10 1.5V, 11 1.8V.
// RQ9 - Fabric sets the selects before raising the strobe.
// RQ10 - Strobe activity during operation updates the rail from present selects.
// RQ11 - Rail must reach power good within 1.5 s of strobe rise.
// RQ12 - Fault-free startup blinks long, short pause, long, long pause once.
// RQ13 - Long segments last about 1 s, short segments about 200 ms.
// RQ14 - Only the highest-priority active fault pattern repeats; priority 0 highest.
// RQ15 - Priority 0 is OR of power-unit fault registers 0x10 to 0x14.
// RQ16 - Priority 1 is OR of registers 0x15 to 0x18, two short blinks.
// RQ17 - Priority 2 is OR of registers 0x19 to 0x1B, three short blinks.
// RQ18 - Fan fault is bit 0 of 0x06, long blink long pause.
// RQ19 - Priority 6 is serial framing or parity error; 7 is OR of 0x70.
// RQ20 - Fan drive follows temperature; speed far from setpoint raises a fault.
// RQ21 - Second mode watches power-unit errors, resets units, records errors.
// RQ22 - Serial link runs 115200 baud, 8 data, even parity, 1 stop.
// RQ23 - Strobe and selects are synchronised before edges so one edge updates once.
module prm_top #(
	parameter int unsigned LONG_CYC  = prm_pkg::LONG_CYC,
	parameter int unsigned SHORT_CYC = prm_pkg::SHORT_CYC,
	parameter int unsigned PG_CYC    = prm_pkg::PG_CYC,
	parameter logic [7:0]  ID_VAL    = 8'hA5,
	parameter logic [7:0]  FW_VER    = 8'h20,
	parameter logic [15:0] RPM_STEP  = 16'h0028,
	parameter logic [15:0] FAN_TOL   = 16'h01F4
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire prm_pkg::prm_wb_req_t   wb_i,
	output prm_pkg::prm_wb_rsp_t        wb_o,
	input  wire prm_pkg::prm_rail_pins_t rail_pins_i,
	input  wire logic                   rail_pgood_i,
	output prm_pkg::prm_rail_out_t      adjustable_io_rail_o,
	input  wire logic                   pod_detect_i,
	output logic                        pod_present_n_o,
	input  wire logic [2:0]             pod_levels_i,
	input  wire logic                   fmc_present_i,
	input  wire logic [2:0]             fmc_levels_i,
	input  wire logic                   mod_fault_i,
	input  wire logic [7:0]             temp_i,
	input  wire logic [15:0]            fan_speed_i,
	output logic [7:0]                  fan_drive_o,
	input  wire logic [11:0]            power_unit_err_i,
	output logic                        power_unit_rst_o,
	output logic                        power_unit_i2c_dis_o,
	input  wire logic                   i2c_stretch_to_i,
	input  wire logic                   uart_rx_i,
	output logic                        status_led_o
);

	typedef struct packed {
		prm_pkg::prm_phase_t ph;
		logic [1:0]  boot_cnt;
		logic        str1, str2, str3;
		logic [1:0]  sel1, sel2;
		logic        pod1, pod2;
		logic        pg1, pg2;
		logic        rx1, rx2;
		logic [11:0] pu1, pu2, pu3;
		logic        pod_n;
		logic        rail_en;
		logic [1:0]  rail_lvl;
		logic        pg_wait;
		logic [27:0] pg_tmr;
		logic        ack;
		logic [31:0] rdat;
		logic [7:0]  scratch;
		logic [7:0]  otlim;
		logic        i2c_dis;
		logic        v2;
		logic        stretch;
		logic        fan_flt;
		logic        ot_flt;
		logic [2:0]  exp_flt;
		logic [11:0] pu_flt;
		logic        pu_rst;
		logic        uart_err;
		logic [7:0]  rx_data;
		logic        rx_busy;
		logic [3:0]  rx_bit;
		logic [10:0] rx_cnt;
		logic [8:0]  rx_sh;
		logic [7:0]  fan_duty;
		logic        show_start;
		logic        led_act;
		logic        led_on;
		logic [3:0]  led_seg;
		logic [3:0]  led_len;
		logic [9:0]  led_mask;
		logic [27:0] led_tmr;
	} prm_state_t;

	prm_state_t  q_ff;
	prm_state_t  nxt_q;
	logic        wb_req;
	logic [6:0]  idx;
	logic        clr_all;
	logic        str_rise;
	logic        str_fall;
	logic        boot_end;
	logic [11:0] pu_new;
	logic [7:0]  flt;
	logic [2:0]  pick;
	logic [2:0]  common;
	logic        any_mod;
	logic        rx_done;
	logic        rx_par_bad;
	logic [15:0] fan_set;
	logic [15:0] fan_diff;

	function automatic logic [27:0] seg_time(input logic is_long);
		seg_time = is_long ? 28'(LONG_CYC - 1) : 28'(SHORT_CYC - 1); // RQ13
	endfunction : seg_time

	function automatic logic [1:0] highest(input logic [2:0] m);
		if (m[2]) begin
			highest = prm_pkg::RAIL_1V8;
		end else if (m[1]) begin
			highest = prm_pkg::RAIL_1V5;
		end else begin
			highest = prm_pkg::RAIL_1V2;
		end
	endfunction : highest

	assign idx      = wb_i.adr[8:2];
	assign wb_req   = wb_i.cyc & wb_i.stb & ~q_ff.ack;
	assign clr_all  = wb_req & wb_i.we & wb_i.sel[0] & (idx == prm_pkg::IDX_CTRL)
		& wb_i.dat[prm_pkg::CTRL_CLR];
	assign str_rise = q_ff.str2 & ~q_ff.str3; // RQ23
	assign str_fall = ~q_ff.str2 & q_ff.str3;
	assign boot_end = (q_ff.ph == prm_pkg::PH_BOOT) && (q_ff.boot_cnt == 2'h3);
	assign pu_new   = q_ff.pu2 & ~q_ff.pu3;
	assign any_mod  = ~q_ff.pod2 | fmc_present_i;
	assign common   = (q_ff.pod2 ? 3'h7 : pod_levels_i) & (fmc_present_i ? fmc_levels_i : 3'h7);
	assign rx_done  = q_ff.rx_busy && (q_ff.rx_cnt == 11'h000) && (q_ff.rx_bit == 4'hA);
	assign rx_par_bad = ^q_ff.rx_sh;
	assign fan_set  = 16'(q_ff.fan_duty * RPM_STEP);
	assign fan_diff = (fan_speed_i > fan_set) ? fan_speed_i - fan_set : fan_set - fan_speed_i;

	always_comb begin
		if (q_ff.v2) begin
			flt = {|q_ff.exp_flt, q_ff.uart_err, q_ff.fan_flt, q_ff.stretch, q_ff.ot_flt, // RQ19
				|q_ff.pu_flt[prm_pkg::PU_N-1:prm_pkg::PU1_N+prm_pkg::PU2_N], // RQ17
				|q_ff.pu_flt[prm_pkg::PU1_N+prm_pkg::PU2_N-1:prm_pkg::PU1_N], // RQ16
				|q_ff.pu_flt[prm_pkg::PU1_N-1:0]}; // RQ15
		end else begin
			flt = 8'h00;
			flt[prm_pkg::FLT_FAN] = q_ff.fan_flt; // RQ18
		end
		pick = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (flt[i]) begin
				pick = 3'(i); // RQ14
			end
		end
	end

	always_comb begin
		nxt_q = q_ff;
		nxt_q.str1 = rail_pins_i.strobe;
		nxt_q.str2 = q_ff.str1;
		nxt_q.str3 = q_ff.str2;
		nxt_q.sel1 = {rail_pins_i.sel_hi, rail_pins_i.sel_lo};
		nxt_q.sel2 = q_ff.sel1;
		nxt_q.pod1 = pod_detect_i;
		nxt_q.pod2 = q_ff.pod1;
		nxt_q.pg1  = rail_pgood_i;
		nxt_q.pg2  = q_ff.pg1;
		nxt_q.rx1  = uart_rx_i;
		nxt_q.rx2  = q_ff.rx1;
		nxt_q.pu1  = power_unit_err_i;
		nxt_q.pu2  = q_ff.pu1;
		nxt_q.pu3  = q_ff.pu2;
		nxt_q.pu_rst = 1'b0;
		nxt_q.ack  = wb_req;

		// Sticky flags: clear first, so a set in the same cycle wins.
		if (clr_all) begin
			nxt_q.fan_flt = 1'b0;
			nxt_q.ot_flt = 1'b0;
			nxt_q.stretch = 1'b0;
			nxt_q.uart_err = 1'b0;
			nxt_q.pu_flt = 12'h000;
			nxt_q.exp_flt = 3'h0;
		end

		// Startup waits for the synchronisers to fill before deciding anything.
		if (q_ff.ph == prm_pkg::PH_BOOT) begin
			nxt_q.boot_cnt = q_ff.boot_cnt + 2'h1;
			if (boot_end) begin
				nxt_q.ph = prm_pkg::PH_RUN;
				nxt_q.pod_n = q_ff.pod2; // RQ1
				nxt_q.show_start = (flt == 8'h00);
				if (q_ff.str2) begin
					nxt_q.rail_lvl = q_ff.sel2; // RQ7
					nxt_q.rail_en = (q_ff.sel2 != prm_pkg::RAIL_OFF); // RQ8
				end else if (q_ff.v2 && any_mod) begin
					if (common == 3'h0) begin
						nxt_q.exp_flt[prm_pkg::EXP_NOCOMMON] = 1'b1; // RQ6
						nxt_q.show_start = 1'b0;
					end else begin
						nxt_q.rail_lvl = highest(common); // RQ5
						nxt_q.rail_en = 1'b1;
					end
				end
			end
		end else begin
			// A falling strobe is deliberately ignored so the rail state holds.
			if (str_rise) begin
				nxt_q.rail_lvl = q_ff.sel2; // RQ2 RQ10
				nxt_q.rail_en = (q_ff.sel2 != prm_pkg::RAIL_OFF); // RQ8 RQ3
				nxt_q.pg_wait = (q_ff.sel2 != prm_pkg::RAIL_OFF);
				nxt_q.pg_tmr = 28'(PG_CYC - 1);
			end else if (q_ff.pg_wait) begin
				if (q_ff.pg2) begin
					nxt_q.pg_wait = 1'b0;
				end else if (q_ff.pg_tmr == 28'h0) begin
					nxt_q.pg_wait = 1'b0;
					nxt_q.exp_flt[prm_pkg::EXP_PGTO] = 1'b1; // RQ11
				end else begin
					nxt_q.pg_tmr = q_ff.pg_tmr - 28'h1;
				end
			end
			if (q_ff.v2 && (pu_new != 12'h000)) begin
				nxt_q.pu_rst = 1'b1; // RQ21
			end
		end

		nxt_q.fan_duty = temp_i; // RQ20
		// The setpoint is zero until the duty has loaded, so speed is judged only when running.
		if ((q_ff.ph == prm_pkg::PH_RUN) && (fan_diff > FAN_TOL)) begin
			nxt_q.fan_flt = 1'b1; // RQ20
		end
		if (q_ff.v2 && (temp_i > q_ff.otlim)) begin
			nxt_q.ot_flt = 1'b1;
		end
		if (q_ff.v2 && i2c_stretch_to_i) begin
			nxt_q.stretch = 1'b1;
		end
		if (mod_fault_i) begin
			nxt_q.exp_flt[prm_pkg::EXP_MOD] = 1'b1;
		end
		if ((q_ff.ph == prm_pkg::PH_RUN) && q_ff.v2) begin
			nxt_q.pu_flt = nxt_q.pu_flt | pu_new; // RQ21
		end

		// Receiver samples mid-bit: start, 8 data, even parity, stop.
		if (!q_ff.rx_busy) begin
			if (!q_ff.rx2) begin
				nxt_q.rx_busy = 1'b1;
				nxt_q.rx_bit = 4'h0;
				nxt_q.rx_cnt = 11'(prm_pkg::BAUD_HALF - 1); // RQ22
			end
		end else if (q_ff.rx_cnt != 11'h000) begin
			nxt_q.rx_cnt = q_ff.rx_cnt - 11'h001;
		end else begin
			nxt_q.rx_cnt = 11'(prm_pkg::BAUD_CYC - 1); // RQ22
			nxt_q.rx_bit = q_ff.rx_bit + 4'h1;
			if (q_ff.rx_bit == 4'h0) begin
				nxt_q.rx_busy = ~q_ff.rx2;
			end else if (q_ff.rx_bit != 4'hA) begin
				nxt_q.rx_sh = {q_ff.rx2, q_ff.rx_sh[8:1]};
			end else begin
				nxt_q.rx_busy = 1'b0;
				nxt_q.rx_data = q_ff.rx_sh[7:0];
				if (!q_ff.rx2 || rx_par_bad) begin
					nxt_q.uart_err = 1'b1; // RQ22 RQ19
				end
			end
		end

		// Status LED sequencer.
		if (!q_ff.led_act) begin
			nxt_q.led_on = 1'b0;
			if ((q_ff.ph == prm_pkg::PH_RUN) && (q_ff.show_start || (flt != 8'h00))) begin
				{nxt_q.led_len, nxt_q.led_mask} = q_ff.show_start ? prm_pkg::PAT_START // RQ12
					: prm_pkg::PAT[pick]; // RQ14
				nxt_q.show_start = 1'b0;
				nxt_q.led_act = 1'b1;
				nxt_q.led_on = 1'b1;
				nxt_q.led_seg = 4'h0;
				nxt_q.led_tmr = seg_time(nxt_q.led_mask[0]);
			end
		end else if (q_ff.led_tmr != 28'h0) begin
			nxt_q.led_tmr = q_ff.led_tmr - 28'h1;
		end else if (q_ff.led_seg == q_ff.led_len - 4'h1) begin
			nxt_q.led_act = 1'b0;
			nxt_q.led_on = 1'b0;
		end else begin
			nxt_q.led_seg = q_ff.led_seg + 4'h1;
			nxt_q.led_on = q_ff.led_seg[0];
			nxt_q.led_tmr = seg_time(q_ff.led_mask[nxt_q.led_seg]);
		end

		// Register access; unmapped words read zero and writes there are dropped.
		if (wb_req && !wb_i.we) begin
			nxt_q.rdat = 32'h0000_0000;
			if (idx == prm_pkg::IDX_ID) begin
				nxt_q.rdat[7:0] = ID_VAL;
			end else if (idx == prm_pkg::IDX_FWVER) begin
				nxt_q.rdat[7:0] = FW_VER;
			end else if (idx == prm_pkg::IDX_SCRATCH) begin
				nxt_q.rdat[7:0] = q_ff.scratch;
			end else if (idx == prm_pkg::IDX_TEMP) begin
				nxt_q.rdat[7:0] = temp_i;
			end else if (idx == prm_pkg::IDX_FANSPD) begin
				nxt_q.rdat[15:0] = fan_speed_i;
			end else if (idx == prm_pkg::IDX_FANFLT) begin
				nxt_q.rdat[prm_pkg::FANFLT_SPD] = q_ff.fan_flt; // RQ18
				nxt_q.rdat[prm_pkg::FANFLT_OT] = q_ff.ot_flt;
			end else if (idx == prm_pkg::IDX_OTLIM) begin
				nxt_q.rdat[7:0] = q_ff.otlim;
			end else if (idx == prm_pkg::IDX_UARTRX) begin
				nxt_q.rdat[7:0] = q_ff.rx_data;
			end else if (idx == prm_pkg::IDX_CTRL) begin
				nxt_q.rdat[prm_pkg::CTRL_I2C_DIS] = q_ff.i2c_dis;
				nxt_q.rdat[prm_pkg::CTRL_V2] = q_ff.v2;
				nxt_q.rdat[prm_pkg::CTRL_STRETCH] = q_ff.stretch;
			end else if ((idx >= prm_pkg::IDX_PU_LO) && (idx <= prm_pkg::IDX_PU_HI)) begin
				nxt_q.rdat[0] = q_ff.pu_flt[4'(idx - prm_pkg::IDX_PU_LO)];
			end else if (idx == prm_pkg::IDX_EXP) begin
				nxt_q.rdat[2:0] = q_ff.exp_flt;
			end
		end
		if (wb_req && wb_i.we && wb_i.sel[0]) begin
			if (idx == prm_pkg::IDX_SCRATCH) begin
				nxt_q.scratch = wb_i.dat[7:0];
			end else if (idx == prm_pkg::IDX_OTLIM) begin
				nxt_q.otlim = wb_i.dat[7:0];
			end else if (idx == prm_pkg::IDX_CTRL) begin
				nxt_q.i2c_dis = wb_i.dat[prm_pkg::CTRL_I2C_DIS];
				nxt_q.v2 = wb_i.dat[prm_pkg::CTRL_V2];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.ph <= prm_pkg::PH_BOOT;
			q_ff.pod_n <= 1'b1;
			q_ff.otlim <= prm_pkg::OTLIM_RST;
			q_ff.v2 <= prm_pkg::CTRL_V2_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign wb_o                       = '{ack: q_ff.ack, dat: q_ff.rdat};
	assign adjustable_io_rail_o       = '{en: q_ff.rail_en, level: q_ff.rail_lvl};
	assign pod_present_n_o            = q_ff.pod_n;
	assign fan_drive_o                = q_ff.fan_duty;
	assign power_unit_rst_o           = q_ff.pu_rst;
	assign power_unit_i2c_dis_o       = q_ff.i2c_dis;
	assign status_led_o               = q_ff.led_on;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_rail_rise_apply: assert property ((q_ff.ph == prm_pkg::PH_RUN) && str_rise // RQ2
		|=> (q_ff.rail_lvl == $past(q_ff.sel2)) && (q_ff.rail_en == ($past(q_ff.sel2) != 2'h0)))
		else $error("rail not set from selects on strobe rise");
	a_rail_fall_hold: assert property ((q_ff.ph == prm_pkg::PH_RUN) && str_fall // RQ3
		|=> $stable(q_ff.rail_en) [*2])
		else $error("rail state changed on strobe fall");
	a_pod_fixed_run: assert property ((q_ff.ph == prm_pkg::PH_RUN) // RQ1
		|=> $stable(pod_present_n_o))
		else $error("pod present output moved after startup");
	a_auto_no_common: assert property (boot_end && q_ff.v2 && !q_ff.str2 && any_mod // RQ6
		&& (common == 3'h0) |=> q_ff.exp_flt[prm_pkg::EXP_NOCOMMON] && !q_ff.rail_en)
		else $error("missing common level not flagged");
	a_led_priority_pick: assert property (!q_ff.led_act && (q_ff.ph == prm_pkg::PH_RUN) // RQ14
		&& !q_ff.show_start && (flt != 8'h00)
		|=> q_ff.led_act && status_led_o && ({q_ff.led_len, q_ff.led_mask} == prm_pkg::PAT[$past(pick)]))
		else $error("led pattern is not the highest priority fault");
	a_uart_err_flag: assert property (rx_done && (rx_par_bad || !q_ff.rx2) // RQ22
		|=> q_ff.uart_err)
		else $error("serial framing or parity error not recorded");
	a_pu_err_reset: assert property ((q_ff.ph == prm_pkg::PH_RUN) && q_ff.v2 // RQ21
		&& (pu_new != 12'h000) |=> power_unit_rst_o ##1 !power_unit_rst_o)
		else $error("power unit reset pulse wrong");
	a_pg_timeout_flag: assert property (q_ff.pg_wait && !str_rise && !q_ff.pg2 // RQ11
		&& (q_ff.pg_tmr == 28'h0) |=> q_ff.exp_flt[prm_pkg::EXP_PGTO])
		else $error("power good timeout not flagged");
	a_ack_one_cycle: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("bus ack held longer than one cycle");

endmodule : prm_top

// *** rtl/prm_pkg.sv ***
package prm_pkg;

	localparam int unsigned CLK_HZ    = 125_000_000;
	localparam int unsigned LONG_MS   = 1000;
	localparam int unsigned SHORT_MS  = 200;
	localparam int unsigned PG_MS     = 1500;
	localparam int unsigned LONG_CYC  = LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned SHORT_CYC = SHORT_MS * (CLK_HZ / 1000);
	localparam int unsigned PG_CYC    = PG_MS * (CLK_HZ / 1000);
	localparam int unsigned BAUD      = 115200;
	localparam int unsigned BAUD_CYC  = CLK_HZ / BAUD;
	localparam int unsigned BAUD_HALF = BAUD_CYC / 2;

	// Register indices; the byte address is four times the index.
	localparam logic [6:0] IDX_ID      = 7'h00;
	localparam logic [6:0] IDX_FWVER   = 7'h01;
	localparam logic [6:0] IDX_SCRATCH = 7'h02;
	localparam logic [6:0] IDX_TEMP    = 7'h03;
	localparam logic [6:0] IDX_FANSPD  = 7'h04;
	localparam logic [6:0] IDX_FANFLT  = 7'h06;
	localparam logic [6:0] IDX_OTLIM   = 7'h08;
	localparam logic [6:0] IDX_UARTRX  = 7'h09;
	localparam logic [6:0] IDX_CTRL    = 7'h0F;
	localparam logic [6:0] IDX_PU_LO   = 7'h10;
	localparam logic [6:0] IDX_PU_HI   = 7'h1B;
	localparam logic [6:0] IDX_EXP     = 7'h70;

	localparam int unsigned PU_N  = 12;
	localparam int unsigned PU1_N = 5;
	localparam int unsigned PU2_N = 4;

	localparam int unsigned CTRL_I2C_DIS = 0;
	localparam int unsigned CTRL_CLR     = 1;
	localparam int unsigned CTRL_V2      = 2;
	localparam int unsigned CTRL_STRETCH = 3;
	localparam int unsigned FANFLT_SPD   = 0;
	localparam int unsigned FANFLT_OT    = 1;
	localparam int unsigned EXP_NOCOMMON = 0;
	localparam int unsigned EXP_PGTO     = 1;
	localparam int unsigned EXP_MOD      = 2;

	localparam logic       CTRL_V2_RST = 1'b1;
	localparam logic [7:0] OTLIM_RST   = 8'h5A;

	localparam logic [1:0] RAIL_OFF = 2'h0;
	localparam logic [1:0] RAIL_1V2 = 2'h1;
	localparam logic [1:0] RAIL_1V5 = 2'h2;
	localparam logic [1:0] RAIL_1V8 = 2'h3;

	// Blink patterns: {segment count, long mask}; segments alternate lit and dark.
	localparam logic [13:0] PAT_START = {4'h4, 10'h00D};
	localparam logic [13:0] PAT [0:7] = '{
		{4'h2, 10'h002}, {4'h4, 10'h008}, {4'h6, 10'h020}, {4'h8, 10'h081},
		{4'hA, 10'h201}, {4'h2, 10'h003}, {4'h6, 10'h021}, {4'h4, 10'h009}};
	localparam int unsigned FLT_FAN = 5;

	typedef enum logic {PH_BOOT, PH_RUN} prm_phase_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [8:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} prm_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} prm_wb_rsp_t;

	typedef struct packed {
		logic strobe;
		logic sel_hi;
		logic sel_lo;
	} prm_rail_pins_t;

	typedef struct packed {
		logic       en;
		logic [1:0] level;
	} prm_rail_out_t;

endpackage : prm_pkg

// *** dv/prm_fabric_model.sv ***
`timescale 1ns/10ps
module prm_fabric_model (
	input  wire logic               clk_i,
	input  wire logic               go_i,
	input  wire logic               hold_i,
	input  wire logic               quiet_i,
	input  wire logic [1:0]         code_i,
	output logic                    done_o,
	output prm_pkg::prm_rail_pins_t pins_o
);
	logic [4:0] cnt_ff;
	initial begin
		pins_o = '0;
		done_o = 1'b0;
		cnt_ff = 5'h00;
	end
	// A quiet request moves only the selects, which the block must then ignore.
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		if (hold_i) begin
			pins_o <= {1'b1, code_i};
		end else if (go_i && cnt_ff == 5'h00) begin
			pins_o.strobe <= 1'b0;
			pins_o.sel_hi <= code_i[1];
			pins_o.sel_lo <= code_i[0];
			cnt_ff <= 5'h01;
		end else if (cnt_ff != 5'h00) begin
			cnt_ff <= cnt_ff + 5'h01;
			if (cnt_ff == 5'h04 && !quiet_i)
				pins_o.strobe <= 1'b1;
			if (cnt_ff == 5'h0A)
				pins_o.strobe <= 1'b0;
			if (cnt_ff == 5'h14) begin
				done_o <= 1'b1;
				cnt_ff <= 5'h00;
			end
		end
	end
endmodule : prm_fabric_model

// *** dv/platform_rail_and_fault_manager_test.sv ***
`timescale 1ns/10ps
module platform_rail_and_fault_manager_test;
	localparam int LC = 40;
	localparam int SC = 8;
	localparam int PC = 50;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	prm_pkg::prm_wb_req_t    wb = '0;
	prm_pkg::prm_wb_rsp_t    wb_rsp;
	prm_pkg::prm_rail_pins_t pins;
	prm_pkg::prm_rail_out_t  rail;
	logic                    pgood = 1'b1;
	logic                    pod_det = 1'b1;
	logic [2:0]              pod_lv = 3'h0;
	logic                    fmc_pr = 1'b0;
	logic [2:0]              fmc_lv = 3'h0;
	logic                    mod_flt = 1'b0;
	logic [7:0]              temp = 8'h10;
	logic [15:0]             fan = 16'h0280;
	logic [7:0]              drive;
	logic [11:0]             pu_err = 12'h000;
	logic                    pu_rst;
	logic                    i2c_dis;
	logic                    stretch = 1'b0;
	logic                    rx = 1'b1;
	logic                    led;
	logic                    pod_n;
	logic                    go = 1'b0;
	logic                    hold = 1'b0;
	logic                    quiet = 1'b0;
	logic [1:0]              code = 2'h0;
	logic                    done;
	logic [31:0]             rd;
	int                      num_errors = 0;
	int                      samples_checked = 0;

	always #4 clk = ~clk;

	prm_top #(.LONG_CYC(LC), .SHORT_CYC(SC), .PG_CYC(PC)) i_prm_top (
		.clk_i(clk), .rst_i(rst), .wb_i(wb), .wb_o(wb_rsp),
		.rail_pins_i(pins), .rail_pgood_i(pgood), .adjustable_io_rail_o(rail),
		.pod_detect_i(pod_det), .pod_present_n_o(pod_n), .pod_levels_i(pod_lv),
		.fmc_present_i(fmc_pr), .fmc_levels_i(fmc_lv), .mod_fault_i(mod_flt),
		.temp_i(temp), .fan_speed_i(fan), .fan_drive_o(drive),
		.power_unit_err_i(pu_err), .power_unit_rst_o(pu_rst), .power_unit_i2c_dis_o(i2c_dis),
		.i2c_stretch_to_i(stretch), .uart_rx_i(rx), .status_led_o(led));

	prm_fabric_model i_prm_fabric_model (
		.clk_i(clk), .go_i(go), .hold_i(hold), .quiet_i(quiet),
		.code_i(code), .done_o(done), .pins_o(pins));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic bus(input logic we, input logic [6:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		wb.cyc <= 1'b1;
		wb.stb <= 1'b1;
		wb.we <= we;
		wb.adr <= {idx, 2'b00};
		wb.sel <= 4'hF;
		wb.dat <= {24'h000000, wd};
		do begin
			@(posedge clk);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		check(wb_rsp.ack, 1'b1);
		rd = wb_rsp.dat;
		wb.cyc <= 1'b0;
		wb.stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rchk(input logic [6:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 8'h00);
		check(rd, exp);
	endtask : rchk

	task automatic clear_faults();
		repeat (4) @(posedge clk);
		bus(1'b1, prm_pkg::IDX_CTRL, 8'h06);
	endtask : clear_faults

	task automatic boot(input logic det, input logic [2:0] pl, input logic [2:0] fl);
		rst <= 1'b1;
		pod_det <= det;
		pod_lv <= pl;
		fmc_pr <= 1'b1;
		fmc_lv <= fl;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
	endtask : boot

	// With sync set, a whole long dark gap is awaited first so counting starts on a repeat.
	task automatic led_seq(input logic sync, input int exp_n, input int exp_first);
		int hi, lo, n, nlit, first;
		lo = 0;
		n = 0;
		nlit = 0;
		first = 0;
		while (sync && lo < LC && n < 3000) begin
			@(posedge clk);
			n++;
			lo = (led === 1'b1) ? 0 : lo + 1;
		end
		while (led !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		lo = 0;
		while (lo < LC && n < 3000) begin
			hi = 0;
			lo = 0;
			while (led === 1'b1 && n < 3000) begin
				@(posedge clk);
				n++;
				hi++;
			end
			while (led !== 1'b1 && lo < LC && n < 3000) begin
				@(posedge clk);
				n++;
				lo++;
			end
			nlit++;
			if (nlit == 1)
				first = hi;
		end
		check(nlit, exp_n);
		check(first, exp_first);
	endtask : led_seq

	task automatic fabric(input logic [1:0] c, input logic q);
		int n;
		code <= c;
		quiet <= q;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(done, 1'b1);
	endtask : fabric

	task automatic uart(input logic [7:0] b, input logic bad);
		logic [10:0] f;
		f = {1'b1, ^b ^ bad, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx <= f[i];
			repeat (prm_pkg::BAUD_CYC) @(posedge clk);
		end
	endtask : uart

	task automatic t_startup();
		int n;
		n = 0;
		boot(1'b0, 3'h3, 3'h6);
		led_seq(1'b0, 2, LC);
		repeat (300) begin
			@(posedge clk);
			n += (led === 1'b1);
		end
		check(n, 0);
		check(rail, {1'b1, prm_pkg::RAIL_1V5});
		check(pod_n, 1'b0);
		rchk(prm_pkg::IDX_FWVER, 32'h20);
		rchk(prm_pkg::IDX_OTLIM, {24'h000000, prm_pkg::OTLIM_RST});
		rchk(prm_pkg::IDX_CTRL, 32'h4);
		bus(1'b1, prm_pkg::IDX_CTRL, 8'h05);
		check(i2c_dis, 1'b1);
		bus(1'b1, prm_pkg::IDX_CTRL, 8'h04);
		check(i2c_dis, 1'b0);
		bus(1'b1, prm_pkg::IDX_SCRATCH, 8'hC3);
		rchk(prm_pkg::IDX_SCRATCH, 32'hC3);
		rchk(7'h40, 32'h0);
		temp <= 8'h14;
		repeat (3) @(posedge clk);
		check(drive, 8'h14);
		temp <= 8'h10;
	endtask : t_startup

	task automatic t_rail();
		logic [1:0] seq [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
		foreach (seq[i]) begin
			fabric(seq[i], 1'b0);
			check(rail.en, seq[i] != 2'h0);
			if (seq[i] != 2'h0)
				check(rail.level, seq[i]);
		end
		fabric(2'h1, 1'b1);
		check(rail, {1'b1, prm_pkg::RAIL_1V5});
		pgood <= 1'b0;
		fabric(2'h3, 1'b0);
		repeat (PC + 10) @(posedge clk);
		rchk(prm_pkg::IDX_EXP, 32'h2);
		pgood <= 1'b1;
		clear_faults();
		rchk(prm_pkg::IDX_EXP, 32'h0);
	endtask : t_rail

	task automatic t_prio();
		int bits [3] = '{0, 5, 9};
		int n;
		foreach (bits[i]) begin
			mod_flt <= 1'b1;
			pu_err[bits[i]] <= 1'b1;
			@(posedge clk);
			mod_flt <= 1'b0;
			n = 0;
			while (pu_rst !== 1'b1 && n < 10) begin
				@(posedge clk);
				n++;
			end
			check(pu_rst, 1'b1);
			rchk(prm_pkg::IDX_PU_LO + 7'(bits[i]), 32'h1);
			led_seq(1'b1, i + 1, SC);
			pu_err <= 12'h000;
			clear_faults();
			rchk(prm_pkg::IDX_PU_LO + 7'(bits[i]), 32'h0);
		end
		uart(8'h3C, 1'b0);
		rchk(prm_pkg::IDX_UARTRX, 32'h3C);
		uart(8'h3C, 1'b1);
		led_seq(1'b1, 3, LC);
		fan <= 16'h0000;
		led_seq(1'b1, 1, LC);
		rchk(prm_pkg::IDX_FANFLT, 32'h1);
		fan <= 16'h0280;
		clear_faults();
		rchk(prm_pkg::IDX_FANFLT, 32'h0);
		stretch <= 1'b1;
		@(posedge clk);
		stretch <= 1'b0;
		rchk(prm_pkg::IDX_CTRL, 32'hC);
		led_seq(1'b1, 5, LC);
		clear_faults();
		// First mode: a module fault stays dark, only the fan fault blinks.
		bus(1'b1, prm_pkg::IDX_CTRL, 8'h00);
		mod_flt <= 1'b1;
		@(posedge clk);
		mod_flt <= 1'b0;
		n = 0;
		repeat (200) @(posedge clk);
		repeat (200) begin
			@(posedge clk);
			n += (led === 1'b1);
		end
		check(n, 0);
		fan <= 16'h0000;
		led_seq(1'b1, 1, LC);
		fan <= 16'h0280;
		clear_faults();
	endtask : t_prio

	task automatic t_boot2();
		boot(1'b0, 3'h1, 3'h4);
		repeat (6) @(posedge clk);
		check(rail.en, 1'b0);
		rchk(prm_pkg::IDX_EXP, 32'h1);
		led_seq(1'b1, 2, LC);
		hold <= 1'b1;
		code <= 2'h3;
		boot(1'b1, 3'h0, 3'h1);
		repeat (6) @(posedge clk);
		check(rail, {1'b1, prm_pkg::RAIL_1V8});
		check(pod_n, 1'b1);
		hold <= 1'b0;
	endtask : t_boot2

	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		$display("BAD %0t run did not finish", $time);
		print_verdict();
	end

	initial begin
		t_startup();
		t_rail();
		t_prio();
		t_boot2();
		print_verdict();
	end
endmodule : platform_rail_and_fault_manager_test
